/* File: common/swdg_map.vh */
`ifndef SWDG_MAP_VH
`define SWDG_MAP_VH

// ***********************************************
// Register byte offsets
// ***********************************************
`define SWDG_OFF_CTRL       8'h00
`define SWDG_OFF_TIMEOUT    8'h04
`define SWDG_OFF_STATUS     8'h08
`define SWDG_OFF_SERVICE    8'h10
`define SWDG_OFF_IRQ_STAT   8'h14
`define SWDG_OFF_IRQ_CLR    8'h18
`define SWDG_OFF_IRQ_EN     8'h1C

// ***********************************************
// Field positions
// ***********************************************
`define SWDG_CTRL_EN_BIT    0
`define SWDG_STAT_LOCK_BIT  0
`define SWDG_STAT_KEY1_BIT  1
`define SWDG_STAT_EN_BIT    2
`define SWDG_IRQ_TOUT_BIT   0
`define SWDG_IRQ_UNLK_BIT   1
`define SWDG_IRQ_SVC_BIT    2
`define SWDG_IRQ_BITS       3

// ***********************************************
// Keys and reset values
// ***********************************************
`define SWDG_KEY_FIRST      16'hC520
`define SWDG_KEY_SECOND     16'hD928
`define SWDG_SVC_FIRST      16'hA602
`define SWDG_SVC_SECOND     16'hB480
`define SWDG_CTRL_RST       32'hFF00010B
`define SWDG_TIMEOUT_RST    32'h0000FFFF
`define SWDG_RST_PULSE_CYC  16

`endif

/* File: rtl/swdg_counter.v */
`timescale 1ns/100ps
// ***********************************************
// Down counter with reload and expiry pulse
// ***********************************************
module swdg_counter #(
   parameter W = 32
) (
   input  wire         clk_sys,
   input  wire         rst_n,
   input  wire         run,
   input  wire         reload,
   input  wire [W-1:0] period,
   output reg          expired,
   output wire [W-1:0] count
);
   reg [W-1:0] cnt_q;

   assign count = cnt_q;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q   <= {W{1'b1}};
         expired <= 1'b0;
      end else begin
         expired <= 1'b0;
         if (reload || !run) begin
            cnt_q <= period;
         end else if (cnt_q == {W{1'b0}}) begin
            expired <= 1'b1;
            cnt_q   <= period;
         end else begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // swdg_counter

/* File: rtl/swdg_top.v */
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
// Overview of operation
// - Unserviced enabled timer expiry resets the system
// - Keys C520 then D928 clear soft lock
// - Cleared enable after unlock stops the timer
// - Service key register at byte 0x10
// - Control at zero; FF00010A write after unlock disables
`include "swdg_map.vh"
module swdg_top #(
   parameter RST_PULSE = `SWDG_RST_PULSE_CYC
) (
   input  wire        clk_sys,
   input  wire        nrst,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output wire        irq,
   output reg         sys_reset_req
);
   // ***********************************************
   // Reset synchroniser
   // ***********************************************
   reg rst_s1_q;
   reg rst_n;
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // ***********************************************
   // Write channel capture
   // ***********************************************
   reg        aw_q;
   reg        w_q;
   reg [7:0]  awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0]  wstrb_q;
   wire       wr_go = aw_q && w_q && !s_axi_bvalid;

   assign s_axi_awready = !aw_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_q && !s_axi_bvalid;

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 32'h00000000;
         wstrb_q  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q     <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q     <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
         end
      end
   end

   // ***********************************************
   // Register decode
   // ***********************************************
   wire full_wr  = (wstrb_q == 4'hF);
   wire wr_ctrl  = wr_go && (awaddr_q == `SWDG_OFF_CTRL);
   wire wr_tout  = wr_go && (awaddr_q == `SWDG_OFF_TIMEOUT);
   wire wr_svc   = wr_go && (awaddr_q == `SWDG_OFF_SERVICE) && full_wr;
   wire wr_iclr  = wr_go && (awaddr_q == `SWDG_OFF_IRQ_CLR);
   wire wr_ien   = wr_go && (awaddr_q == `SWDG_OFF_IRQ_EN);
   wire wr_map   = wr_ctrl || wr_tout || (wr_go && awaddr_q == `SWDG_OFF_SERVICE) ||
                   wr_iclr || wr_ien || (wr_go && awaddr_q == `SWDG_OFF_STATUS) ||
                   (wr_go && awaddr_q == `SWDG_OFF_IRQ_STAT);

   // ***********************************************
   // Control, lock and key sequence
   // ***********************************************
   reg [31:0] ctrl_q;
   reg [31:0] tout_q;
   reg        lock_q;
   reg        key1_q;
   reg        svc1_q;
   reg        init_q;
   wire [15:0] key = wdata_q[15:0];
   wire        en  = ctrl_q[`SWDG_CTRL_EN_BIT];
   wire        unlock_ev  = wr_svc && key1_q && (key == `SWDG_KEY_SECOND);
   wire        service_ev = wr_svc && svc1_q && (key == `SWDG_SVC_SECOND);

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= `SWDG_CTRL_RST;
         tout_q <= `SWDG_TIMEOUT_RST;
         lock_q <= 1'b1;
         key1_q <= 1'b0;
         svc1_q <= 1'b0;
         init_q <= 1'b0;
      end else begin
         init_q <= 1'b1;
         if (wr_svc) begin
            key1_q <= (key == `SWDG_KEY_FIRST);
            svc1_q <= (key == `SWDG_SVC_FIRST);
         end
         if (unlock_ev) begin
            lock_q <= 1'b0;
         end
         if (wr_ctrl && !lock_q && full_wr) begin
            ctrl_q <= wdata_q;
            lock_q <= 1'b1;
         end
         if (wr_tout && !lock_q && full_wr) begin
            tout_q <= wdata_q;
         end
      end
   end

   // ***********************************************
   // Timer and system reset request
   // ***********************************************
   wire expired;
   wire [31:0] count;
   swdg_counter #(.W(32)) u_cnt (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .run     (en),
      .reload  (service_ev || !init_q),
      .period  (tout_q),
      .expired (expired),
      .count   (count)
   );

   reg [7:0] rst_cnt_q;
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sys_reset_req <= 1'b0;
         rst_cnt_q     <= 8'h00;
      end else if (expired && en) begin
         sys_reset_req <= 1'b1;
         rst_cnt_q     <= RST_PULSE[7:0];
      end else if (rst_cnt_q != 8'h00) begin
         rst_cnt_q <= rst_cnt_q - 8'h01;
      end else begin
         sys_reset_req <= 1'b0;
      end
   end

   // ***********************************************
   // Interrupt status, clear and enable
   // ***********************************************
   reg  [`SWDG_IRQ_BITS-1:0] ist_q;
   reg  [`SWDG_IRQ_BITS-1:0] ien_q;
   wire [`SWDG_IRQ_BITS-1:0] ev  = {service_ev, unlock_ev, expired && en};
   wire [`SWDG_IRQ_BITS-1:0] clr = wr_iclr ? wdata_q[`SWDG_IRQ_BITS-1:0] : {`SWDG_IRQ_BITS{1'b0}};

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ist_q <= {`SWDG_IRQ_BITS{1'b0}};
         ien_q <= {`SWDG_IRQ_BITS{1'b0}};
      end else begin
         ist_q <= (ist_q & ~clr) | ev;
         if (wr_ien) begin
            ien_q <= wdata_q[`SWDG_IRQ_BITS-1:0];
         end
      end
   end
   assign irq = |(ist_q & ien_q);

   // ***********************************************
   // Write response
   // ***********************************************
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_map ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // ***********************************************
   // Read channel
   // ***********************************************
   reg [31:0] rd_d;
   reg        rd_ok;
   assign s_axi_arready = !s_axi_rvalid;

   always @* begin
      rd_ok = 1'b1;
      case (s_axi_araddr)
         `SWDG_OFF_CTRL:     rd_d = ctrl_q;
         `SWDG_OFF_TIMEOUT:  rd_d = tout_q;
         `SWDG_OFF_STATUS:   rd_d = {29'h0, en, key1_q, lock_q};
         `SWDG_OFF_SERVICE:  rd_d = count;
         `SWDG_OFF_IRQ_STAT: rd_d = {29'h0, ist_q};
         `SWDG_OFF_IRQ_CLR:  rd_d = 32'h00000000;
         `SWDG_OFF_IRQ_EN:   rd_d = {29'h0, ien_q};
         default: begin
            rd_d  = 32'h00000000;
            rd_ok = 1'b0;
         end
      endcase
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_d;
         s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // swdg_top

/* File: dv/swdg_top_monitor.sv */
`timescale 1ns/100ps
module swdg_top_monitor #(
   parameter RST_PULSE = 16
) (
   input wire clk_sys,
   input wire nrst,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire sys_reset_req
);
   // ***********
   // Pulse length
   // ***********
   reg [7:0] pulse_q;
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) pulse_q <= 8'h00;
      else pulse_q <= sys_reset_req ? pulse_q + 8'h01 : 8'h00;
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   AST_WR_ANSWER: assert property (wr_taken |=> ##1 s_axi_bvalid)
      else $error("write answer missing");
   AST_WR_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   AST_WR_CLOSE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write answer not closed");
   AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read answer missing");
   AST_RD_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   AST_RD_CLOSE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read answer not closed");
   AST_RST_PULSE: assert property ($fell(sys_reset_req) |-> pulse_q == RST_PULSE + 1)
      else $error("reset request length wrong");
endmodule // swdg_top_monitor

/* File: dv/swdg_top_tb.sv */
`timescale 1ns/100ps
`include "swdg_map.vh"
module swdg_top_tb;
   localparam RST_PULSE = 16;
   localparam logic [41:0] ROWS [5] = '{
      {`SWDG_OFF_CTRL, `SWDG_CTRL_RST, 2'b00}, {`SWDG_OFF_TIMEOUT, `SWDG_TIMEOUT_RST, 2'b00},
      {`SWDG_OFF_STATUS, 32'h00000005, 2'b00}, {`SWDG_OFF_IRQ_STAT, 32'h00000000, 2'b00},
      {8'h20, 32'h00000000, 2'b10}};
   logic        clk_sys, nrst, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, irq, srr;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rdat, got;
   logic [3:0]  ws;
   logic [1:0]  bresp, rresp, gr;
   int          fail_count = 0, total_checks = 0, i, n;
   swdg_top #(.RST_PULSE(RST_PULSE)) DUT (.clk_sys(clk_sys), .nrst(nrst),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .irq(irq), .sys_reset_req(srr));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      begin
         total_checks++;
         if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   // ***********
   // Bus access
   // ***********
   task bus(input logic rd_op, input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, td;
      begin
         @(posedge clk_sys);
         if (rd_op) begin
            ara <= a;
            arv <= 1'b1;
            rr <= 1'b1;
         end else begin
            awa <= a;
            wd <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            br <= 1'b1;
         end
         n = 0;
         td = 1'b0;
         while (!td) begin
            #1;
            ta = (awv && awr) || (arv && arr);
            tw = wv && wrdy;
            td = (bv && br) || (rv && rr);
            gr = rd_op ? rresp : bresp;
            got = rdat;
            @(posedge clk_sys);
            if (ta) awv <= 1'b0;
            if (ta) arv <= 1'b0;
            if (tw) wv <= 1'b0;
            if (td) br <= 1'b0;
            if (td) rr <= 1'b0;
            n++;
         end
      end
   endtask
   task unl;
      begin
         bus(1'b0, `SWDG_OFF_SERVICE, {16'h0000, `SWDG_KEY_FIRST});
         bus(1'b0, `SWDG_OFF_SERVICE, {16'h0000, `SWDG_KEY_SECOND});
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d mismatches %0d", total_checks, fail_count);
         if (fail_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
         end else begin
            $display("Run complete: FAIL");
         end
         $finish;
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      tally_and_finish;
   end
   initial begin
      {nrst, awv, wv, br, arv, rr, awa, ara, wd} = '0;
      ws = 4'hF;
      repeat (8) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      for (i = 0; i < 5; i++) begin
         bus(1'b1, ROWS[i][41:34], 32'h0);
         chk("row data", ROWS[i][33:2], got);
         chk("row resp", {30'h0, ROWS[i][1:0]}, {30'h0, gr});
      end
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped resp", 32'h2, {30'h0, gr});
      bus(1'b0, `SWDG_OFF_CTRL, 32'hFF00010A);
      bus(1'b1, `SWDG_OFF_CTRL, 32'h0);
      chk("ctrl locked", `SWDG_CTRL_RST, got);
      bus(1'b0, `SWDG_OFF_SERVICE, {16'h0000, `SWDG_KEY_FIRST});
      bus(1'b0, `SWDG_OFF_SERVICE, 32'h00001234);
      bus(1'b0, `SWDG_OFF_SERVICE, {16'h0000, `SWDG_KEY_SECOND});
      bus(1'b1, `SWDG_OFF_STATUS, 32'h0);
      chk("status broken", 32'h5, got);
      unl;
      bus(1'b1, `SWDG_OFF_STATUS, 32'h0);
      chk("status open", 32'h4, got);
      bus(1'b0, `SWDG_OFF_TIMEOUT, 32'h20);
      bus(1'b0, `SWDG_OFF_CTRL, 32'hFF00010A);
      bus(1'b1, `SWDG_OFF_STATUS, 32'h0);
      chk("status off", 32'h1, got);
      repeat (100) @(posedge clk_sys);
      bus(1'b1, `SWDG_OFF_IRQ_STAT, 32'h0);
      chk("no expiry", 32'h2, got);
      // ***********
      // Expiry and interrupt
      // ***********
      unl;
      bus(1'b0, `SWDG_OFF_IRQ_EN, 32'h1);
      bus(1'b0, `SWDG_OFF_CTRL, `SWDG_CTRL_RST);
      bus(1'b0, `SWDG_OFF_SERVICE, {16'h0000, `SWDG_SVC_FIRST});
      bus(1'b0, `SWDG_OFF_SERVICE, {16'h0000, `SWDG_SVC_SECOND});
      n = 0;
      while (srr !== 1'b1 && n < 200) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk("expiry time", 32'h1, {31'h0, n >= 28 && n <= 40});
      repeat (2) @(posedge clk_sys);
      chk("irq raised", 32'h1, {31'h0, irq});
      unl;
      bus(1'b0, `SWDG_OFF_CTRL, 32'hFF00010A);
      bus(1'b0, `SWDG_OFF_IRQ_EN, 32'h0);
      chk("irq masked", 32'h0, {31'h0, irq});
      bus(1'b0, `SWDG_OFF_IRQ_EN, 32'h7);
      chk("irq unmasked", 32'h1, {31'h0, irq});
      bus(1'b0, `SWDG_OFF_IRQ_CLR, 32'h7);
      bus(1'b1, `SWDG_OFF_IRQ_STAT, 32'h0);
      chk("irq stat clear", 32'h0, got);
      chk("irq cleared", 32'h0, {31'h0, irq});
      // ***********
      // Reset in mid-run
      // ***********
      nrst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("reset req low", 32'h0, {31'h0, srr});
      chk("irq after reset", 32'h0, {31'h0, irq});
      bus(1'b1, `SWDG_OFF_CTRL, 32'h0);
      chk("ctrl after reset", `SWDG_CTRL_RST, got);
      bus(1'b1, `SWDG_OFF_SERVICE, 32'h0);
      chk("count loaded", 32'h0, got & 32'hFFFF0000);
      tally_and_finish;
   end
endmodule // swdg_top_tb
bind swdg_top swdg_top_monitor #(.RST_PULSE(RST_PULSE)) mon (.clk_sys(clk_sys), .nrst(nrst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .sys_reset_req(sys_reset_req));
